//--- verilog/ucc_defs.svh
// register offsets, reset values and fixed counts of the capture/compare timer
// assumes inclusion by bare name from the design file
`ifndef UCC_DEFS_SVH
`define UCC_DEFS_SVH
// ======================================================================
// byte offsets on the apb side
`define UCC_OFS_CTRL 8'h00
`define UCC_OFS_STAT 8'h04
`define UCC_OFS_COUNT 8'h08
`define UCC_OFS_CH_BASE 8'h10
`define UCC_OFS_CH_END 8'h48
// ======================================================================
// field positions
`define UCC_CTRL_CLR_BIT 9
`define UCC_CTRL_WIDTH 9
`define UCC_CCTL_WIDTH 14
`define UCC_CCTL_LEVEL_BIT 14
// ======================================================================
// reset values
`define UCC_CTRL_RST 9'h000
`define UCC_CCTL_RST 14'h0000
`define UCC_WORD_RST 16'h0000
// ======================================================================
// counts
`define UCC_CHANNELS 7
`define UCC_MAX_8 16'h00FF
`define UCC_MAX_10 16'h03FF
`define UCC_MAX_12 16'h0FFF
`define UCC_MAX_16 16'hFFFF
`endif

//--- verilog/ucc_pkg.sv
// types shared by the capture/compare timer
// assumes the defs header supplies the numbers
package ucc_pkg;
    typedef enum logic [1:0] {
        UCC_STOP,
        UCC_UP,
        UCC_CONT,
        UCC_UPDN
    } ucc_mode_t;

    typedef struct packed {
        logic float_sel;
        logic [1:0] latch_group_mode;
        logic [1:0] div;
        logic [1:0] len;
        ucc_mode_t mode;
    } ucc_ctrl_t;

    typedef struct packed {
        logic drive_level_bit;
        logic [2:0] waveform_mode_select;
        logic [1:0] latch_load_mode;
        logic channel_event_flag;
        logic sample_overrun;
        logic sample_sync;
        logic [1:0] edge_choice;
        logic [1:0] sample_source_select;
        logic mode_is_sampling;
    } ucc_cctl_t;
endpackage

//--- verilog/ucc_timer.sv
// up/down counter, seven capture/compare channels and output units
// assumes an apb master on pclk; pins are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defs.svh"

// Overview of operation
// R01: up/down with period above length maximum acts continuous, never wraps down.
// R02: direction survives stop; clear bit zeroes direction, count and divider.
// R03: up/down sets channel 0 flag at period, wrap flag at one-to-zero.
// R04: period change while descending only applies after reaching zero.
// R05: rising with a new period at or above count, climb to it.
// R06: rising with new period below count, turn down; one extra count allowed.
// R07: seven identical channels, each capture or compare.
// R08: capture copies count on chosen edge of chosen input, sets flag.
// R09: sync bit aligns capture to next timer clock edge.
// R10: second capture before read sets overrun; only software clears it.
// R11: fixed source with toggle bit gives one software capture per toggle.
// R12: compare mode flags and pulses match when count reaches channel latch.
// R13: latch hidden; loaded from buffer on write or at zero.
// R14: mode 10 loads at zero or, in up/down only, at old period; mode 11 at old latch.
// R15: group mode selects none, pairs, triples or all channels.
// R16: lowest member governs, channel 1 for all; zero governor means immediate.
// R17: group loads only after every member buffer written, then load event.
// R18: float pin selected and high puts every output high impedance.
// R19: waveform output changes on timer clock, except mode 000 follows drive bit and mode 001 clears on the clear bit.
// R20: modes 001 set, 101 reset, 100 toggle on channel match.
// R21: modes 010 toggle/reset and 011 set/reset on channel/period match.
// R22: modes 110 toggle/set and 111 reset/set on channel/period match.
module ucc_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] sample_input_a,
    input wire logic [6:0] sample_input_b,
    input wire logic float_all_pin,
    output logic [6:0] unit_signal,
    output logic [6:0] unit_oe_n
);
    // ==================================================================
    // helpers
    function automatic logic [2:0] ucc_gov(input logic [2:0] n,
                                           input logic [1:0] g);
        logic [2:0] r;
        r = n;
        unique case (g)
            2'h0: r = n;
            2'h1: r = n[0] ? n : ((n == 3'h0) ? 3'h0 : n - 3'h1);
            2'h2: r = (n == 3'h0) ? 3'h0 : ((n <= 3'h3) ? 3'h1 : 3'h4);
            2'h3: r = 3'h1;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] ucc_max(input logic [1:0] len);
        logic [15:0] r;
        r = `UCC_MAX_16;
        unique case (len)
            2'h0: r = `UCC_MAX_8;
            2'h1: r = `UCC_MAX_10;
            2'h2: r = `UCC_MAX_12;
            2'h3: r = `UCC_MAX_16;
        endcase
        return r;
    endfunction

    // ==================================================================
    // state
    ucc_pkg::ucc_ctrl_t ctrl;
    ucc_pkg::ucc_cctl_t cctl [7];
    logic [15:0] count, next_count, maxc, per;
    logic [15:0] chan_buf [7];
    logic [15:0] chan_latch [7];
    logic dir, next_dir, wrap_flag;
    logic [2:0] div_cnt;
    logic tclk, run, step, zero_evt;
    logic [6:0] sa1, sa2, sa3, sa_f, sb1, sb2, sb3, sb_f;
    logic [2:0] fl_s;
    logic fl_f, float_on;
    logic [6:0] lvl, lvl_d, cap_req, cap_do, pend, unread, written;
    logic [6:0] match, load, imm;

    // ==================================================================
    // apb decode
    logic acc, wr, rd, in_ch, clr;
    logic [7:0] choff;
    logic [2:0] ch;
    logic [31:0] next_rdata;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign in_ch = paddr >= `UCC_OFS_CH_BASE && paddr < `UCC_OFS_CH_END;
    assign choff = paddr - `UCC_OFS_CH_BASE;
    assign ch = choff[5:3];
    assign clr = wr && paddr == `UCC_OFS_CTRL && pwdata[`UCC_CTRL_CLR_BIT];
    assign maxc = ucc_max(ctrl.len);
    assign per = chan_latch[0];

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (paddr == `UCC_OFS_CTRL) begin
            next_rdata[8:0] = ctrl;
        end else if (paddr == `UCC_OFS_STAT) begin
            next_rdata[2:0] = {fl_f, dir, wrap_flag};
        end else if (paddr == `UCC_OFS_COUNT) begin
            next_rdata[15:0] = count;
        end else if (in_ch && paddr[2]) begin
            next_rdata[15:0] = chan_buf[ch];
        end else if (in_ch) begin
            next_rdata[`UCC_CCTL_LEVEL_BIT:0] = {lvl[ch], cctl[ch]};
        end
    end

    // zero wait states; read data prepared during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= !(in_ch || paddr == `UCC_OFS_CTRL
                    || paddr == `UCC_OFS_STAT || paddr == `UCC_OFS_COUNT)
                    || paddr[1:0] != 2'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `UCC_CTRL_RST;
        end else if (wr && paddr == `UCC_OFS_CTRL) begin
            ctrl <= pwdata[`UCC_CTRL_WIDTH-1:0];
        end
    end

    // ==================================================================
    // pin synchronisers: change accepted when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sa1, sa2, sa3, sa_f} <= 28'h0000000;
            {sb1, sb2, sb3, sb_f} <= 28'h0000000;
            {fl_s, fl_f} <= 4'h0;
        end else begin
            {sa3, sa2, sa1} <= {sa2, sa1, sample_input_a};
            {sb3, sb2, sb1} <= {sb2, sb1, sample_input_b};
            fl_s <= {fl_s[1:0], float_all_pin};
            for (int i = 0; i < 7; i++) begin
                if (sa2[i] == sa3[i]) sa_f[i] <= sa3[i];
                if (sb2[i] == sb3[i]) sb_f[i] <= sb3[i];
            end
            if (fl_s[1] == fl_s[2]) fl_f <= fl_s[2];
        end
    end

    // ==================================================================
    // divider and counter
    assign tclk = div_cnt == 3'h0;
    assign run = ctrl.mode != ucc_pkg::UCC_STOP
        && !(ctrl.mode != ucc_pkg::UCC_CONT && per == 16'h0000);
    assign step = tclk && run;
    assign zero_evt = step && next_count == 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 3'h0;
        end else if (clr) begin
            div_cnt <= 3'h0; // see R02
        end else begin
            div_cnt <= tclk ? 3'((4'h1 << ctrl.div) - 4'h1) : div_cnt - 3'h1;
        end
    end

    always_comb begin
        next_count = count;
        next_dir = dir;
        unique case (ctrl.mode)
            ucc_pkg::UCC_STOP: next_count = count;
            ucc_pkg::UCC_UP:
                next_count = (count >= per) ? 16'h0000 : count + 16'h0001;
            ucc_pkg::UCC_CONT:
                next_count = (count >= maxc) ? 16'h0000 : count + 16'h0001;
            ucc_pkg::UCC_UPDN: begin
                if (per > maxc) begin
                    // see R01
                    next_count = (count >= maxc) ? 16'h0000 : count + 16'h0001;
                end else if (!dir) begin
                    // a lowered period below count turns at once, see R06
                    if (count >= per) begin
                        next_dir = 1'b1;
                        next_count = count - 16'h0001;
                    end else begin
                        next_count = count + 16'h0001; // see R05
                    end
                end else begin
                    // descent ignores the period, see R04
                    next_count = count - 16'h0001;
                    if (count == 16'h0001) next_dir = 1'b0;
                end
            end
        endcase
    end

    // direction is only touched by counting or clear, see R02
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `UCC_WORD_RST;
            dir <= 1'b0;
        end else if (clr) begin
            count <= `UCC_WORD_RST; // see R02
            dir <= 1'b0;
        end else if (wr && paddr == `UCC_OFS_COUNT) begin
            count <= pwdata[15:0] & maxc;
        end else if (step) begin
            count <= next_count;
            dir <= next_dir;
        end
    end

    // hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_flag <= 1'b0;
        end else if (step && next_count == 16'h0000 && count != 16'h0000) begin
            wrap_flag <= 1'b1; // see R03
        end else if (wr && paddr == `UCC_OFS_STAT) begin
            wrap_flag <= pwdata[0];
        end
    end

    // ==================================================================
    // capture path
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            unique case (cctl[i].sample_source_select)
                2'h0: lvl[i] = sa_f[i];
                2'h1: lvl[i] = sb_f[i];
                2'h2: lvl[i] = 1'b0; // see R11
                2'h3: lvl[i] = 1'b1;
            endcase
            cap_req[i] = cctl[i].mode_is_sampling
                && ((cctl[i].edge_choice[0] && lvl[i] && !lvl_d[i])
                || (cctl[i].edge_choice[1] && !lvl[i] && lvl_d[i])); // see R08
            cap_do[i] = cctl[i].sample_sync
                ? (cap_req[i] || pend[i]) && tclk : cap_req[i]; // see R09
            match[i] = step && !cctl[i].mode_is_sampling
                && next_count == chan_latch[i]; // see R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_d <= 7'h00;
            pend <= 7'h00;
            unread <= 7'h00;
        end else begin
            lvl_d <= lvl;
            for (int i = 0; i < 7; i++) begin
                pend[i] <= cctl[i].sample_sync
                    && (cap_req[i] || pend[i]) && !tclk;
                if (cap_do[i]) unread[i] <= 1'b1;
                else if (rd && in_ch && paddr[2] && ch == 3'(i))
                    unread[i] <= 1'b0;
            end
        end
    end

    // one register set per channel, see R07
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 7; i++) cctl[i] <= `UCC_CCTL_RST;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (wr && in_ch && !paddr[2] && ch == 3'(i))
                    cctl[i] <= pwdata[`UCC_CCTL_WIDTH-1:0];
                if (cap_do[i] || match[i])
                    cctl[i].channel_event_flag <= 1'b1;
                if (cap_do[i] && unread[i])
                    cctl[i].sample_overrun <= 1'b1; // see R10
            end
        end
    end

    // ==================================================================
    // buffer and hidden compare latch, see R13
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            logic [2:0] g;
            logic done;
            logic ev;
            g = ucc_gov(3'(i), ctrl.latch_group_mode); // see R15
            done = 1'b1;
            for (int m = 0; m < 7; m++) begin
                if (ucc_gov(3'(m), ctrl.latch_group_mode) == g)
                    done = done && written[m]; // see R17
            end
            ev = 1'b0;
            unique case (cctl[g].latch_load_mode) // see R16
                2'h0: ev = 1'b0;
                2'h1: ev = zero_evt;
                2'h2: ev = zero_evt || (step && ctrl.mode == ucc_pkg::UCC_UPDN
                    && next_count == per); // see R14
                2'h3: ev = step && next_count == chan_latch[g];
            endcase
            imm[i] = cctl[g].latch_load_mode == 2'h0;
            load[i] = !imm[i] && ev && done;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written <= 7'h00;
            for (int i = 0; i < 7; i++) begin
                chan_buf[i] <= `UCC_WORD_RST;
                chan_latch[i] <= `UCC_WORD_RST;
            end
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (cap_do[i]) begin
                    chan_buf[i] <= count; // see R08
                end else if (wr && in_ch && paddr[2] && ch == 3'(i)) begin
                    chan_buf[i] <= pwdata[15:0];
                    if (imm[i]) chan_latch[i] <= pwdata[15:0]; // see R13
                end
                if (load[i]) chan_latch[i] <= chan_buf[i];
                if (wr && in_ch && paddr[2] && ch == 3'(i) && !imm[i])
                    written[i] <= 1'b1;
                else if (load[i] || imm[i])
                    written[i] <= 1'b0;
            end
        end
    end

    // ==================================================================
    // output units; mode 000 lags the write by one pclk only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_signal <= 7'h00;
        end else begin
            for (int i = 0; i < 7; i++) begin
                unique case (cctl[i].waveform_mode_select) // see R19
                    3'h0: unit_signal[i] <= cctl[i].drive_level_bit;
                    3'h1: begin
                        if (clr) unit_signal[i] <= 1'b0;
                        else if (match[i]) unit_signal[i] <= 1'b1; // see R20
                    end
                    3'h2: begin
                        if (match[0]) unit_signal[i] <= 1'b0; // see R21
                        else if (match[i]) unit_signal[i] <= !unit_signal[i];
                    end
                    3'h3: begin
                        if (match[0]) unit_signal[i] <= 1'b0; // see R21
                        else if (match[i]) unit_signal[i] <= 1'b1;
                    end
                    3'h4: if (match[i]) unit_signal[i] <= !unit_signal[i];
                    3'h5: if (match[i]) unit_signal[i] <= 1'b0; // see R20
                    3'h6: begin
                        if (match[0]) unit_signal[i] <= 1'b1; // see R22
                        else if (match[i]) unit_signal[i] <= !unit_signal[i];
                    end
                    3'h7: begin
                        if (match[0]) unit_signal[i] <= 1'b1; // see R22
                        else if (match[i]) unit_signal[i] <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign float_on = ctrl.float_sel && fl_f;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) unit_oe_n <= 7'h00;
        else unit_oe_n <= {7{float_on}}; // see R18
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_updn_no_wrap: assert property ( // see R01
        ctrl.mode == ucc_pkg::UCC_UPDN && per > maxc && step && !clr
        && count == maxc && !wr |=> count == 16'h0000)
        else $error("up/down above max did not roll over");
    a_clear_all: assert property (clr |=> count == 16'h0000 && !dir // see R02
        && div_cnt == 3'h0) else $error("clear left state behind");
    a_wrap_set: assert property ( // see R03
        step && ctrl.mode == ucc_pkg::UCC_UPDN && dir && count == 16'h0001
        && per <= maxc |=> wrap_flag) else $error("wrap flag missed");
    a_down_hold: assert property ( // see R04
        step && !clr && !wr && ctrl.mode == ucc_pkg::UCC_UPDN && per <= maxc
        && dir && count > 16'h0001 |=> count == $past(count) - 16'h0001)
        else $error("descent interrupted");
    a_cap_copy: assert property (cap_do[1] |=> // see R08
        chan_buf[1] == $past(count) && cctl[1].channel_event_flag)
        else $error("capture not stored");
    a_ovr_set: assert property (cap_do[1] && unread[1] |=> // see R10
        cctl[1].sample_overrun) else $error("overrun not flagged");
    a_latch_load: assert property (load[1] |=> // see R13
        chan_latch[1] == $past(chan_buf[1])) else $error("latch not loaded");
    a_float_out: assert property (float_on |=> &unit_oe_n) // see R18
        else $error("outputs not floated");
    a_set_mode: assert property ( // see R20
        match[1] && cctl[1].waveform_mode_select == 3'h1 && !clr
        |=> unit_signal[1]) else $error("set mode did not set");

    c_capture: cover property (cap_do[1] ##[1:100] cap_do[1]);
    c_group_load: cover property (load[1] && load[2]);
    c_updn_wrap: cover property (step && dir && count == 16'h0001);
endmodule
`default_nettype wire

//--- verif/ucc_pin_model.sv
// pin-side partner: capture sources and the float pin of the timer
// assumes the bench calls its tasks from the pclk domain
`timescale 1ns/1ps
`default_nettype none
module ucc_pin_model (
    input wire logic pclk,
    output logic [6:0] sample_input_a,
    output logic [6:0] sample_input_b,
    output logic float_all_pin
);
    // ==================================================================
    // pin levels
    initial begin
        sample_input_a = 7'h00;
        sample_input_b = 7'h00;
        float_all_pin = 1'b0;
    end
    // unselected source keeps moving, so a wrong select shows up
    always @(posedge pclk) begin
        sample_input_b <= ~sample_input_b;
    end
    // level held eight clocks: the pin synchroniser needs four
    task automatic set_a(input int ch, input logic v);
        @(posedge pclk);
        sample_input_a[ch] <= v;
        repeat (8) @(posedge pclk);
    endtask
    task automatic set_float(input logic v);
        @(posedge pclk);
        float_all_pin <= v;
        repeat (8) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench of the capture/compare timer
// assumes the design and the pin model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defs.svh"
module tb;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
    } ucc_note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic float_all_pin;
    logic [6:0] sample_input_a;
    logic [6:0] sample_input_b;
    logic [6:0] unit_signal;
    logic [6:0] unit_oe_n;
    ucc_note_t notes[$];
    ucc_note_t n;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'hC47F;
    logic [15:0] rv;
    always #5 pclk = ~pclk;
    ucc_timer i_ucc_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_input_a(sample_input_a), .sample_input_b(sample_input_b),
        .float_all_pin(float_all_pin), .unit_signal(unit_signal),
        .unit_oe_n(unit_oe_n));
    ucc_pin_model i_ucc_pin_model (.pclk(pclk),
        .sample_input_a(sample_input_a), .sample_input_b(sample_input_b),
        .float_all_pin(float_all_pin));
    // ==================================================================
    // shared tasks
    task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("counts: %0d checks, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge pclk);
    endtask
    // a read notes data masked by m; the monitor does the compare
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
            logic [31:0] m = 32'h0);
        if (!wr) notes.push_back('{d & m, m});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] cc(int ch, int r);
        return 8'(`UCC_OFS_CH_BASE + 8 * ch + 4 * r);
    endfunction
    // ==================================================================
    // monitor and timeout
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                compare("read note", 32'h1, 32'h0);
            end else begin
                n = notes.pop_front();
                compare("prdata", n.exp, prdata & n.mask);
            end
        end
    end
    // ==================================================================
    // scenarios
    initial begin
        tick(12);
        presetn <= 1'b1;
        tick(2);
        apb(1'b0, `UCC_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, cc(3, 0), 32'h0, 32'h3FFF);
        compare("pslverr", 32'h0, {31'h0, pslverr});
        apb(1'b0, 8'hFC, 32'h0, 32'hFFFFFFFF);
        compare("pslverr", 32'h1, {31'h0, pslverr});
        $display("done: reset values");
        // up/down: direction latched across stop, flags once per period
        apb(1'b1, cc(0, 0), 32'h0);
        apb(1'b1, cc(0, 1), 32'h10);
        apb(1'b1, `UCC_OFS_CTRL, 32'h20F);
        tick(20);
        apb(1'b1, `UCC_OFS_CTRL, 32'h00C);
        apb(1'b0, `UCC_OFS_STAT, 32'h2, 32'h3);
        apb(1'b0, cc(0, 0), 32'h80, 32'h80);
        apb(1'b1, `UCC_OFS_CTRL, 32'h00F);
        tick(2);
        apb(1'b1, `UCC_OFS_CTRL, 32'h00C);
        apb(1'b0, `UCC_OFS_STAT, 32'h2, 32'h2);
        apb(1'b1, `UCC_OFS_CTRL, 32'h20C);
        apb(1'b0, `UCC_OFS_COUNT, 32'h0, 32'hFFFF);
        apb(1'b0, `UCC_OFS_STAT, 32'h0, 32'h2);
        apb(1'b1, `UCC_OFS_CTRL, 32'h00F);
        tick(36);
        apb(1'b1, `UCC_OFS_CTRL, 32'h00C);
        apb(1'b0, `UCC_OFS_STAT, 32'h1, 32'h1);
        $display("done: up/down direction and flags");
        // period above the 8-bit maximum: never turns down
        apb(1'b1, cc(0, 1), 32'h1FF);
        apb(1'b1, `UCC_OFS_CTRL, 32'h213);
        tick(600);
        apb(1'b1, `UCC_OFS_CTRL, 32'h000);
        apb(1'b0, `UCC_OFS_STAT, 32'h0, 32'h2);
        $display("done: oversized period");
        // capture on rising edges of input a, overrun until cleared by a write
        rv = 16'($random(seed));
        apb(1'b1, `UCC_OFS_CTRL, 32'h20C);
        apb(1'b1, `UCC_OFS_COUNT, {16'h0, rv});
        apb(1'b1, cc(1, 0), 32'h0009);
        i_ucc_pin_model.set_a(1, 1'b1);
        apb(1'b0, cc(1, 0), 32'h4080, 32'h40C0);
        apb(1'b0, cc(1, 1), {16'h0, rv}, 32'hFFFF);
        i_ucc_pin_model.set_a(1, 1'b0);
        i_ucc_pin_model.set_a(1, 1'b1);
        apb(1'b0, cc(1, 0), 32'h4080, 32'h40C0);
        i_ucc_pin_model.set_a(1, 1'b0);
        i_ucc_pin_model.set_a(1, 1'b1);
        apb(1'b0, cc(1, 0), 32'h40C0, 32'h40C0);
        apb(1'b1, cc(1, 0), 32'h0009);
        apb(1'b0, cc(1, 0), 32'h0, 32'h40);
        // software capture by toggling between fixed levels
        apb(1'b1, cc(2, 0), 32'h003D);
        apb(1'b0, cc(2, 0), 32'h0, 32'h80);
        apb(1'b1, cc(2, 0), 32'h003F);
        tick(3);
        apb(1'b0, cc(2, 0), 32'h80, 32'h80);
        apb(1'b0, cc(2, 1), {16'h0, rv}, 32'hFFFF);
        $display("done: capture");
        // mode 000 follows the drive bit on every channel
        for (int ch = 0; ch < 7; ch++) apb(1'b1, cc(ch, 0), 32'h2000);
        tick(2);
        compare("unit_signal", 32'h7F, {25'h0, unit_signal});
        for (int ch = 0; ch < 7; ch++) apb(1'b1, cc(ch, 0), 32'h0);
        tick(2);
        compare("unit_signal", 32'h0, {25'h0, unit_signal});
        // modes 1..7 before and after the period match at 0x80
        apb(1'b1, cc(0, 1), 32'h80);
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, `UCC_OFS_CTRL, 32'h200);
            for (int ch = 1; ch < 7; ch++) begin
                apb(1'b1, cc(ch, 0), 32'h0);
                apb(1'b1, cc(ch, 1), 32'h20);
                apb(1'b1, cc(ch, 0), 32'((((ch - 1 + p) % 7) + 1) << 10));
            end
            apb(1'b1, `UCC_OFS_CTRL, 32'h202);
            tick(80);
            for (int ch = 1; ch < 7; ch++)
                compare("unit_signal", 32'(8'h5E >> (((ch - 1 + p) % 7) + 1)) & 1,
                    32'(unit_signal[ch]));
            tick(80);
            for (int ch = 1; ch < 7; ch++)
                compare("unit_signal", 32'(8'hD2 >> (((ch - 1 + p) % 7) + 1)) & 1,
                    32'(unit_signal[ch]));
        end
        apb(1'b1, `UCC_OFS_CTRL, 32'h000);
        $display("done: waveform modes");
        // float pin puts every output in high impedance
        apb(1'b1, `UCC_OFS_CTRL, 32'h100);
        i_ucc_pin_model.set_float(1'b1);
        compare("unit_oe_n", 32'h7F, {25'h0, unit_oe_n});
        i_ucc_pin_model.set_float(1'b0);
        compare("unit_oe_n", 32'h0, {25'h0, unit_oe_n});
        $display("done: float pin");
        // pairs grouped: ch1 latch waits for the ch2 buffer, loads at zero
        apb(1'b1, `UCC_OFS_CTRL, 32'h240);
        apb(1'b1, cc(1, 0), 32'h1100);
        apb(1'b1, cc(1, 1), 32'h90);
        apb(1'b1, `UCC_OFS_CTRL, 32'h042);
        tick(300);
        compare("unit_signal", 32'h0, 32'(unit_signal[1]));
        apb(1'b1, cc(2, 1), 32'h0);
        tick(250);
        compare("unit_signal", 32'h0, 32'(unit_signal[1]));
        $display("done: grouped latches");
        tick(2);
        conclude();
    end
endmodule
`default_nettype wire
